// ===== hdl/crf_pkg.sv
// Constants shared by the conversion readback framer and its byte FIFO.
// Assumes a single mclk domain for all users of these values.
package crf_pkg;

  localparam int BYTE_W   = 8;
  localparam int WORD_W   = 32;
  localparam int AUX_W    = 24;
  localparam int RAW_W    = 34;
  localparam int AUX_RAW_W = 26;
  localparam int ALM_W    = 4;
  localparam int FIFO_DEPTH = 8;

  // Interface configuration register and its flag-byte enable
  localparam logic [7:0] IFACE_CFG_ADDR      = 8'h02;
  localparam int         IFACE_STATUS_EN_BIT = 2;

  // Flag byte layout
  localparam int FLAG_AUX_BIT  = 7;
  localparam int FLAG_MAIN_BIT = 6;
  localparam int FLAG_CLK_BIT  = 5;
  localparam int FLAG_REF_BIT  = 4;
  localparam int FLAG_PGAL_BIT = 3;
  localparam int FLAG_PGAH_BIT = 2;
  localparam int FLAG_PGAD_BIT = 1;
  localparam int FLAG_RST_BIT  = 0;

  // Alarm vector order on the alarm input
  localparam int ALM_REF  = 3;
  localparam int ALM_PGAL = 2;
  localparam int ALM_PGAH = 1;
  localparam int ALM_PGAD = 0;

  // Sequence layout, counted with the flag byte present
  localparam logic [2:0] BASE_LEN = 3'h4;
  localparam logic [2:0] POS_FLAG = 3'h0;
  localparam logic [2:0] POS_CHK  = 3'h5;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  localparam logic signed [RAW_W-1:0] MAIN_MAX = 34'sh0_7fff_ffff;
  localparam logic signed [RAW_W-1:0] AUX_MAX  = 34'sh0_007f_ffff;

  typedef enum logic [1:0] {
    CRF_IDLE = 2'b01,
    CRF_FILL = 2'b10
  } crf_state_type;

endpackage

// ===== hdl/crf_fifo.sv
// Byte FIFO with a registered head word, valid/ready on both sides.
// Assumes DEPTH is a power of two; flush empties it in one cycle.
`timescale 1ns/1ps
module crf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,      // Master clock
  input  wire logic             rst,       // Synchronous reset
  input  wire logic             flush,     // Drop all entries
  input  wire logic             in_valid,  // Write request
  output logic                  in_ready,  // Room for a word
  input  wire logic [WIDTH-1:0] in_data,   // Write data
  output logic                  out_valid, // Head word present
  input  wire logic             out_ready, // Head word taken
  output logic [WIDTH-1:0]      out_data   // Head word
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 cnt;
    logic                        head_valid;
    logic [WIDTH-1:0]            head;
  } crf_fifo_type;

  crf_fifo_type s_reg;
  crf_fifo_type s_next;
  logic         push;
  logic         pop;
  logic         load;

  assign in_ready  = (s_reg.cnt != (PW+1)'(DEPTH)) && !flush;
  assign out_valid = s_reg.head_valid;
  assign out_data  = s_reg.head;
  assign push      = in_valid && in_ready;
  assign pop       = out_ready && s_reg.head_valid;
  assign load      = (!s_reg.head_valid || pop) && (s_reg.cnt != '0);

  always_comb begin
    s_next = s_reg;
    if (load) begin
      s_next.head       = s_reg.mem[s_reg.rd_ptr];
      s_next.head_valid = 1'b1;
      s_next.rd_ptr     = s_reg.rd_ptr + 1'b1;
    end else if (pop) begin
      s_next.head_valid = 1'b0;
    end
    if (push) begin
      s_next.mem[s_reg.wr_ptr] = in_data;
      s_next.wr_ptr            = s_reg.wr_ptr + 1'b1;
    end
    s_next.cnt = s_reg.cnt + (PW+1)'(push) - (PW+1)'(load);
    if (flush) begin
      s_next.wr_ptr     = '0;
      s_next.rd_ptr     = '0;
      s_next.cnt        = '0;
      s_next.head_valid = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule // crf_fifo

// ===== hdl/crf_framer.sv
// Conversion readback framer: builds flag, result and check bytes, shifts
// them out on the serial clock. Assumes command decode, checksum and
// power register live outside; sclk, cs_n and alarms are asynchronous.
// Behaviour
// RULE_01: main sequence is 4, 5 or 6 bytes
// RULE_02: order is flag, word MSB first, check
// RULE_03: aux sends three word bytes plus zero pad
// RULE_04: without flag byte, word starts the sequence
// RULE_05: flag byte only when config bit 2 set
// RULE_06: flag bit 7 marks new aux data
// RULE_07: flag bit 6 marks new main data
// RULE_08: flag bit 5 reports external clock in use
// RULE_09: flag bit 4 mirrors low-reference alarm
// RULE_10: flag bit 3 mirrors amplifier low alarm
// RULE_11: flag bit 2 mirrors amplifier high alarm
// RULE_12: flag bit 1 mirrors differential range alarm
// RULE_13: flag bit 0 mirrors power register reset flag
// RULE_14: host trusts aux new flag only by command
// RULE_15: host trusts alarm bits only with main data
// RULE_16: main result 32-bit two's complement, MSB first
// RULE_17: zero input gives all-zero code
// RULE_18: host may truncate main word to 24 bits
// RULE_19: aux result 24-bit two's complement, MSB first
// RULE_20: host reads main by 12h/13h, aux 14h/15h
// RULE_21: extra clocking restarts the sequence at byte one
// RULE_22: out-of-range results saturate, never wrap
// RULE_23: check byte from outside, sent only when enabled
`timescale 1ns/1ps
module crf_framer
  import crf_pkg::*;
#(
  parameter int FIFO_WORDS = crf_pkg::FIFO_DEPTH
) (
  input  wire logic                            mclk,          // Master clock
  input  wire logic                            rst,           // Synchronous reset
  input  wire logic                            sclk,          // Serial clock pin
  input  wire logic                            cs_n,          // Chip select pin
  output logic                                 dout,          // Serial data out
  input  wire logic [7:0]                      iface_cfg,     // Interface config register
  input  wire logic                            chk_en,        // Check byte enabled
  input  wire logic [crf_pkg::BYTE_W-1:0]      chk_byte,      // Checksum from outside
  input  wire logic                            start_read,    // Read command decoded, pulse
  input  wire logic                            read_aux,      // Read targets aux converter
  input  wire logic signed [crf_pkg::RAW_W-1:0] main_raw,     // Main converter raw result
  input  wire logic                            main_valid,    // Main result updated, pulse
  input  wire logic signed [crf_pkg::AUX_RAW_W-1:0] aux_raw,  // Aux converter raw result
  input  wire logic                            aux_valid,     // Aux result updated, pulse
  input  wire logic                            ext_clk_sel,   // External clock in use
  input  wire logic [crf_pkg::ALM_W-1:0]       alarm_in,      // Analog alarms, async
  input  wire logic                            reset_flag,    // Power register reset flag
  output logic [crf_pkg::BYTE_W-1:0]           readback_flag_byte, // Live flag byte
  output logic                                 frame_busy     // Readback in progress
);
  import crf_pkg::*;

  typedef struct packed {
    crf_state_type         state;
    logic [2:0]            sclk_sync;
    logic [1:0]            cs_sync;
    logic [ALM_W-1:0]      alm_s1;
    logic [ALM_W-1:0]      alm_s2;
    logic                  main_new;
    logic                  aux_new;
    logic [BYTE_W-1:0]     flag_live;
    logic [BYTE_W-1:0]     flag_snap;
    logic [WORD_W-1:0]     word_snap;
    logic [BYTE_W-1:0]     chk_snap;
    logic                  is_aux;
    logic                  status_en;
    logic [2:0]            idx;
    logic [2:0]            len;
    logic [BYTE_W-1:0]     shift;
    logic [3:0]            bit_left;
    logic                  dout;
  } crf_main_type;

  crf_main_type      s_reg;
  crf_main_type      s_next;
  logic              sclk_rise;
  logic              cs_high;
  logic              take;
  logic              push;
  logic              in_ready;
  logic              pop;
  logic              head_valid;
  logic [BYTE_W-1:0] head_byte;
  logic [BYTE_W-1:0] push_byte;
  logic [2:0]        pos;
  logic [WORD_W-1:0] main_sat;
  logic [WORD_W-1:0] aux_sat;
  logic [BYTE_W-1:0] flag_now;

  // Clamp a raw result to the signed range of the chosen converter
  function automatic logic [WORD_W-1:0] crf_sat(input logic signed [RAW_W-1:0] v,
                                                input logic is_aux);
    logic signed [RAW_W-1:0] hi;
    logic signed [RAW_W-1:0] lo;
    logic signed [RAW_W-1:0] r;
    hi = is_aux ? AUX_MAX : MAIN_MAX;
    lo = -hi - 34'sh1;
    if (v > hi) begin
      r = hi;
    end else if (v < lo) begin
      r = lo;
    end else begin
      r = v;
    end
    return r[WORD_W-1:0];                                              // see RULE_17
  endfunction

  // Byte at a sequence position, counted with the flag byte present
  function automatic logic [BYTE_W-1:0] crf_pick(input logic [2:0] p,
                                                 input logic [BYTE_W-1:0] flag,
                                                 input logic [WORD_W-1:0] word,
                                                 input logic [BYTE_W-1:0] chk);
    logic [BYTE_W-1:0] b;
    b = chk;
    if (p == POS_FLAG) begin
      b = flag;
    end else if (p < POS_CHK) begin
      b = word[WORD_W-1-8*(int'(p)-1) -: BYTE_W];
    end
    return b;
  endfunction

  assign main_sat  = crf_sat(main_raw, 1'b0);                          // see RULE_22
  assign aux_sat   = crf_sat(RAW_W'(aux_raw), 1'b1);                   // see RULE_22
  assign sclk_rise = s_reg.sclk_sync[1] && !s_reg.sclk_sync[2];
  assign cs_high   = s_reg.cs_sync[1];
  assign take      = (s_reg.state == CRF_IDLE) && start_read && !cs_high;
  assign pos       = s_reg.idx + {2'b00, !s_reg.status_en};            // see RULE_04
  assign push_byte = crf_pick(pos, s_reg.flag_snap, s_reg.word_snap,
                              s_reg.chk_snap);                          // see RULE_02
  assign push      = (s_reg.state == CRF_FILL) && in_ready;
  assign pop       = (s_reg.state == CRF_FILL) && sclk_rise
                     && (s_reg.bit_left == 4'h0) && head_valid;

  always_comb begin
    flag_now                = '0;
    flag_now[FLAG_AUX_BIT]  = s_reg.aux_new;                           // see RULE_06
    flag_now[FLAG_MAIN_BIT] = s_reg.main_new;                          // see RULE_07
    flag_now[FLAG_CLK_BIT]  = ext_clk_sel;                             // see RULE_08
    flag_now[FLAG_REF_BIT]  = s_reg.alm_s2[ALM_REF];                   // see RULE_09
    flag_now[FLAG_PGAL_BIT] = s_reg.alm_s2[ALM_PGAL];                  // see RULE_10
    flag_now[FLAG_PGAH_BIT] = s_reg.alm_s2[ALM_PGAH];                  // see RULE_11
    flag_now[FLAG_PGAD_BIT] = s_reg.alm_s2[ALM_PGAD];                  // see RULE_12
    flag_now[FLAG_RST_BIT]  = reset_flag;                              // see RULE_13
  end

  always_comb begin
    s_next           = s_reg;
    s_next.sclk_sync = {s_reg.sclk_sync[1:0], sclk};
    s_next.cs_sync   = {s_reg.cs_sync[0], cs_n};
    s_next.alm_s1    = alarm_in;
    s_next.alm_s2    = s_reg.alm_s1;
    s_next.flag_live = flag_now;
    // A read clears its new-data flag; a fresh result in the same cycle wins
    if (take && !read_aux) begin
      s_next.main_new = 1'b0;
    end
    if (take && read_aux) begin
      s_next.aux_new = 1'b0;
    end
    if (main_valid) begin
      s_next.main_new = 1'b1;                                          // see RULE_07
    end
    if (aux_valid) begin
      s_next.aux_new = 1'b1;                                           // see RULE_06
    end
    case (s_reg.state)
      CRF_IDLE: begin
        s_next.idx      = '0;
        s_next.bit_left = '0;
        s_next.dout     = 1'b0;
        if (take) begin
          s_next.state     = CRF_FILL;
          s_next.is_aux    = read_aux;
          s_next.flag_snap = flag_now;
          s_next.status_en = iface_cfg[IFACE_STATUS_EN_BIT];           // see RULE_05
          s_next.chk_snap  = chk_byte;                                 // see RULE_23
          s_next.len       = BASE_LEN + {2'b00, iface_cfg[IFACE_STATUS_EN_BIT]}
                             + {2'b00, chk_en};                        // see RULE_01
          s_next.word_snap = read_aux ? {aux_sat[AUX_W-1:0], PAD_BYTE}
                                      : main_sat;                      // see RULE_03
        end
      end
      CRF_FILL: begin
        if (push) begin
          s_next.idx = (s_reg.idx == s_reg.len - 3'h1) ? 3'h0
                                                       : s_reg.idx + 3'h1; // see RULE_21
        end
        if (sclk_rise) begin
          if (s_reg.bit_left == 4'h0) begin
            if (head_valid) begin
              s_next.dout     = head_byte[BYTE_W-1];                   // see RULE_16
              s_next.shift    = {head_byte[BYTE_W-2:0], 1'b0};
              s_next.bit_left = BITS_PER_BYTE - 4'h1;
            end else begin
              s_next.dout = 1'b0;
            end
          end else begin
            s_next.dout     = s_reg.shift[BYTE_W-1];                   // see RULE_19
            s_next.shift    = {s_reg.shift[BYTE_W-2:0], 1'b0};
            s_next.bit_left = s_reg.bit_left - 4'h1;
          end
        end
        if (cs_high) begin
          s_next.state = CRF_IDLE;
        end
      end
      default: begin
        s_next.state = CRF_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg         <= '0;
      s_reg.state   <= CRF_IDLE;
      s_reg.cs_sync <= 2'b11; // Idle level, no false select after reset
    end else begin
      s_reg <= s_next;
    end
  end

  crf_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .flush     (s_reg.state == CRF_IDLE),
    .in_valid  (s_reg.state == CRF_FILL),
    .in_ready  (in_ready),
    .in_data   (push_byte),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head_byte)
  );

  assign dout               = s_reg.dout;
  assign readback_flag_byte = s_reg.flag_live;
  assign frame_busy         = (s_reg.state == CRF_FILL);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_seq_length: assert property (take |=> s_reg.len == BASE_LEN // see RULE_01
      + {2'b00, $past(iface_cfg[IFACE_STATUS_EN_BIT])} + {2'b00, $past(chk_en)})
    else $error("sequence length wrong");
  a_first_byte: assert property (push && s_reg.idx == 3'h0 && !s_reg.status_en // see RULE_04
      |-> push_byte == s_reg.word_snap[WORD_W-1 -: BYTE_W])
    else $error("first byte is not the word head");
  a_flag_first: assert property (push && s_reg.idx == 3'h0 && s_reg.status_en // see RULE_05
      |-> push_byte == s_reg.flag_snap)
    else $error("flag byte not first");
  a_pad_zero: assert property (push && s_reg.is_aux && pos == 3'h4 // see RULE_03
      |-> push_byte == PAD_BYTE)
    else $error("aux pad byte not zero");
  a_main_new: assert property (main_valid |=> s_reg.main_new ##1 // see RULE_07
      readback_flag_byte[FLAG_MAIN_BIT])
    else $error("main new-data flag missed");
  a_aux_new: assert property (aux_valid |=> s_reg.aux_new) // see RULE_06
    else $error("aux new-data flag missed");
  a_alarm_path: assert property ($stable(alarm_in) [*4] |-> // see RULE_09
      readback_flag_byte[FLAG_REF_BIT] == alarm_in[ALM_REF])
    else $error("reference alarm not mirrored");
  a_reset_mirror: assert property (readback_flag_byte[FLAG_RST_BIT] // see RULE_13
      == $past(reset_flag))
    else $error("reset flag not mirrored");
  a_seq_restart: assert property (push && s_reg.idx == s_reg.len - 3'h1 // see RULE_21
      |=> s_reg.idx == 3'h0)
    else $error("sequence did not restart");
  a_sat_high: assert property (take && !read_aux && main_raw > MAIN_MAX // see RULE_22
      |=> s_reg.word_snap == 32'h7fff_ffff)
    else $error("main result wrapped");
  a_chk_byte: assert property (push && pos == POS_CHK |-> push_byte == s_reg.chk_snap) // see RULE_23
    else $error("check byte wrong");
  a_clk_source: assert property (readback_flag_byte[FLAG_CLK_BIT] // see RULE_08
      == $past(ext_clk_sel))
    else $error("clock source flag not mirrored");
  a_amp_low: assert property ($stable(alarm_in) [*4] |-> // see RULE_10
      readback_flag_byte[FLAG_PGAL_BIT] == alarm_in[ALM_PGAL])
    else $error("amplifier low alarm not mirrored");
  a_amp_high: assert property ($stable(alarm_in) [*4] |-> // see RULE_11
      readback_flag_byte[FLAG_PGAH_BIT] == alarm_in[ALM_PGAH])
    else $error("amplifier high alarm not mirrored");
  a_diff_range: assert property ($stable(alarm_in) [*4] |-> // see RULE_12
      readback_flag_byte[FLAG_PGAD_BIT] == alarm_in[ALM_PGAD])
    else $error("differential range alarm not mirrored");
  a_zero_code: assert property (take && !read_aux && main_raw == '0 // see RULE_17
      |=> s_reg.word_snap == 32'h0000_0000)
    else $error("zero result not all-zero code");
  a_aux_sat_low: assert property (take && read_aux // see RULE_22
      && RAW_W'(aux_raw) < -AUX_MAX - 34'sh1 |=> s_reg.word_snap == 32'h8000_0000)
    else $error("aux result wrapped");
  a_msb_first: assert property (pop |=> dout == $past(head_byte[BYTE_W-1])) // see RULE_16
    else $error("byte not sent msb first");

  c_main_read: cover property (take && !read_aux);
  c_aux_read: cover property (take && read_aux);
  c_restart: cover property (push && s_reg.idx == s_reg.len - 3'h1 ##1 push);
  c_fifo_full: cover property (s_reg.state == CRF_FILL && !in_ready);
  c_no_flag: cover property (take && !iface_cfg[IFACE_STATUS_EN_BIT]);

endmodule // crf_framer

// ===== tb/crf_host_model.sv
// Host-side serial controller model driving sclk and cs_n, capturing dout.
// Assumes dout settles within 70 ns of an sclk rise; sclk idles low.
`timescale 1ns/1ps
module crf_host_model (
  output logic      sclk, // Serial clock, still outside frames
  output logic      cs_n, // Chip select, active low
  input  wire logic dout  // Serial data from device
);
  logic [7:0] rx [0:15]; // Captured bytes

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end

  // Select, then give the device time to see it before the command
  task automatic select();
    #3.3 cs_n = 1'b0;
    #40;
  endtask

  // Bytes MSB first; sampled late in the period, well after dout moves
  // Flag byte judged by the bench, alarms only in main frames
  task automatic shift(input int n);
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        sclk = 1'b1;
        #40 sclk = 1'b0;
        #30 rx[i][b] = dout;
        #10;
      end
    end
  endtask

  task automatic deselect();
    #20 cs_n = 1'b1;
  endtask
endmodule // crf_host_model

// ===== tb/testbench.sv
// Self-checking bench for the readback framer with a host serial model.
// Assumes sclk at 80 ns and mclk at 10 ns, unrelated in phase.
`timescale 1ns/1ps
module testbench;
  import crf_pkg::*;
  logic                        mclk, rst, sclk, cs_n, dout, chk_en, start_read;
  logic                        read_aux, main_valid, aux_valid, ext_clk_sel;
  logic                        reset_flag, frame_busy, main_new, aux_new;
  logic [7:0]                  iface_cfg, chk_byte, readback_flag_byte;
  logic signed [RAW_W-1:0]     main_raw;
  logic signed [AUX_RAW_W-1:0] aux_raw;
  logic [ALM_W-1:0]            alarm_in;
  int                          mismatches, comparisons;

  crf_framer i_crf_framer (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .dout(dout), .iface_cfg(iface_cfg), .chk_en(chk_en), .chk_byte(chk_byte),
    .start_read(start_read), .read_aux(read_aux), .main_raw(main_raw),
    .main_valid(main_valid), .aux_raw(aux_raw), .aux_valid(aux_valid),
    .ext_clk_sel(ext_clk_sel), .alarm_in(alarm_in), .reset_flag(reset_flag),
    .readback_flag_byte(readback_flag_byte), .frame_busy(frame_busy));

  crf_host_model i_crf_host_model (.sclk(sclk), .cs_n(cs_n), .dout(dout));

  always #5 mclk = ~mclk;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (frame_busy !== v && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (frame_busy !== v) begin
      mismatches++;
      $display("[ERR] frame_busy wait expected %b seen %b", v, frame_busy);
      finish_test();
    end
  endtask

  // Update one converter result with a valid pulse
  task automatic load(input logic aux, input logic signed [33:0] raw);
    @(negedge mclk);
    if (aux) begin
      aux_raw = raw[25:0];
      aux_valid = 1'b1;
    end else begin
      main_raw = raw;
      main_valid = 1'b1;
    end
    @(negedge mclk);
    main_valid = 1'b0;
    aux_valid = 1'b0;
    if (aux) aux_new = 1'b1;
    else main_new = 1'b1;
    repeat (4) @(negedge mclk);
  endtask

  // One readback; word holds the expected result bytes MSB first
  task automatic read(input logic aux, input logic fen, input logic cen,
                      input logic [31:0] word, input logic [7:0] ck);
    logic [7:0] exp [0:5];
    logic [7:0] m;
    logic [23:0] t;
    int         len, k;
    len = 0;
    if (fen) begin
      exp[0] = {aux_new, main_new, 6'h35};
      len = 1;
    end
    for (k = 0; k < 4; k++) exp[len + k] = word[31 - 8 * k -: 8];
    len += 4;
    if (cen) begin
      exp[len] = ck;
      len++;
    end
    iface_cfg = 8'hfb | (8'(fen) << IFACE_STATUS_EN_BIT);
    chk_en = cen;
    chk_byte = ck;
    i_crf_host_model.select();
    @(negedge mclk);
    start_read = 1'b1; // Stands for a decoded read opcode
    read_aux = aux;
    @(negedge mclk);
    start_read = 1'b0;
    if (aux) aux_new = 1'b0;
    else main_new = 1'b0;
    wait_busy(1'b1);
    chk_byte = ~ck;
    i_crf_host_model.shift(len + 2);
    for (k = 0; k < len + 2; k++) begin
      m = (aux && fen && (k % len) == 0) ? 8'he1 : 8'hff;
      check("rx byte", i_crf_host_model.rx[k] & m, exp[k % len] & m);
    end
    k = int'(fen);
    t = {i_crf_host_model.rx[k], i_crf_host_model.rx[k + 1], i_crf_host_model.rx[k + 2]};
    if (!aux) check("truncated word", 32'(t), 32'(word[31:8]));
    i_crf_host_model.deselect();
    wait_busy(1'b0);
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    {chk_en, start_read, read_aux, main_valid, aux_valid} = 5'h00;
    {ext_clk_sel, alarm_in, reset_flag} = 6'h00;
    {iface_cfg, chk_byte, main_raw, aux_raw} = '0;
    {main_new, aux_new, mismatches, comparisons} = '0;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    check("flag after reset", readback_flag_byte, 32'h00);
    check("busy after reset", frame_busy, 32'h0);
    for (int b = 0; b < 6; b++) begin
      {ext_clk_sel, alarm_in, reset_flag} = 6'h01 << b;
      repeat (5) @(negedge mclk);
      check("flag bit", readback_flag_byte, 32'h01 << b);
    end
    {ext_clk_sel, alarm_in, reset_flag} = 6'h35;
    @(negedge mclk);
    start_read = 1'b1;
    @(negedge mclk);
    start_read = 1'b0;
    repeat (4) @(negedge mclk);
    check("refused start", frame_busy, 32'h0);
    load(1'b0, 34'sh1_0000_0000);
    check("main new flag", readback_flag_byte, 32'h75);
    read(1'b0, 1'b1, 1'b1, 32'h7fffffff, 8'h5a);
    read(1'b0, 1'b1, 1'b0, 32'h7fffffff, 8'h00);
    load(1'b0, 34'sh0);
    read(1'b0, 1'b0, 1'b0, 32'h00000000, 8'h00);
    load(1'b0, -34'sd4294967297);
    read(1'b0, 1'b0, 1'b1, 32'h80000000, 8'ha5);
    load(1'b1, 34'sh123456);
    check("aux new flag", readback_flag_byte, 32'hb5);
    read(1'b1, 1'b1, 1'b0, 32'h12345600, 8'h00);
    load(1'b1, -34'sd33554432);
    read(1'b1, 1'b1, 1'b1, 32'h80000000, 8'hc3);
    check("flags after reads", readback_flag_byte, 32'h35);
    finish_test();
  end
endmodule // testbench
